// File: avalon_reg_slave.sv
`timescale 1ns/1ns
module avalon_reg_slave
  import power_mode_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  input wire logic [31:0] rd_value_i,
  output logic waitrequest_o,
  output logic [31:0] readdata_o,
  output logic wr_stb_o,
  output logic [ADDR_W-1:0] wr_addr_o,
  output logic [7:0] wr_data_o
);
  // ****************************************************************
  // one wait state, then a single-cycle accept
  // ****************************************************************
  // waitrequest is a flop of its own so the bus never sees a decode glitch
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      waitrequest_o <= 1'b1;
      readdata_o <= '0;
      wr_stb_o <= 1'b0;
      wr_addr_o <= '0;
      wr_data_o <= '0;
    end
    else if (clk_en_i)
    begin
      wr_stb_o <= 1'b0;
      if ((read_i || write_i) && waitrequest_o)
      begin
        waitrequest_o <= 1'b0;
        readdata_o <= rd_value_i;
        // only byte lane 0 carries register data
        wr_stb_o <= write_i && byteenable_i[0];
        wr_addr_o <= address_i;
        wr_data_o <= writedata_i[7:0];
      end
      else
      begin
        waitrequest_o <= 1'b1;
      end
    end
  end
endmodule

// File: cpu_core_model.sv
`timescale 1ns/1ns
module cpu_core_model
(
  input wire logic ref_clk_i,
  input wire logic waitrequest_i,
  input wire logic [31:0] readdata_i,
  output logic [power_mode_pkg::ADDR_W-1:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o,
  output logic [3:0] byteenable_o,
  output logic stop_instr_o,
  output logic halt_instr_o
);
  import power_mode_pkg::*;
  // ****
  // bus master and instruction pulses
  // ****
  initial
  begin
    address_o = '0;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = '0;
    byteenable_o = 4'h1;
    stop_instr_o = 1'b0;
    halt_instr_o = 1'b0;
  end
  // request held until waitrequest is seen low; only the bench timeout ends a hang
  task automatic access(input logic [ADDR_W-1:0] a, input logic wr, input logic [7:0] d,
    output logic [31:0] q);
    @(posedge ref_clk_i);
    address_o <= a;
    // reserved power control bits always go out as zero
    writedata_o <= {24'h0, (a == PERIPH_PWR_DIS_OFFSET) ? (d & 8'h9e) : d};
    read_o <= !wr;
    write_o <= wr;
    do
      @(posedge ref_clk_i);
    while (waitrequest_i !== 1'b0);
    q = readdata_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
  endtask
  // amplifier state is left as software set it before stop
  task automatic instr(input logic stop);
    @(posedge ref_clk_i);
    stop_instr_o <= stop;
    halt_instr_o <= !stop;
    @(posedge ref_clk_i);
    stop_instr_o <= 1'b0;
    halt_instr_o <= 1'b0;
  endtask
endmodule

// File: low_power_mode_control.sv
// Summary of operation
// R1: stop instruction enters stop; all but brown-out, amplifier, watchdog power down.
// R2: stop halts main and precision oscillators, frees crystal pins, restores port pins.
// R3: stop freezes system clock, cpu and program counter.
// R4: watchdog oscillator and logic keep running in stop when enabled.
// R5: brown-out runs in stop only when its nonvolatile option enables it.
// R6: amplifier runs in stop whenever its enable bit allows.
// R7: halt mode powers down only the cpu.
// R8: active mode is neither stop nor halt; peripherals switch off individually.
// R9: stop is left only through stop-mode recovery.
// R10: power control register reset only by power-on reset.
// R11: bit 7 disables amplifier when set, also in stop; resets to 1.
// R12: bit 4 disables brown-out; active needs bit clear and option set.
// R13: bits 3, 2, 1 disable temperature sensor, converter, comparator.
// R14: software writes zero to reserved bits 6:5 and 0.
// R15: software should disable the amplifier before stop if unused.
// R16: writes take effect next cycle; reads return every stored bit.
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ns
module low_power_mode_control
  import power_mode_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  input wire logic por_n_i,
  input wire logic [power_mode_pkg::ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic waitrequest_o,
  output logic [31:0] readdata_o,
  input wire logic stop_instr_i,
  input wire logic halt_instr_i,
  input wire logic halt_wake_i,
  input wire logic stop_recovery_i,
  input wire logic brownout_always_on_option_i,
  input wire logic brownout_stop_option_i,
  input wire logic wdt_osc_enable_i,
  input wire logic wdt_enable_i,
  output power_mode_pkg::power_mode_e mode_o,
  output power_mode_pkg::periph_enable_s periph_en_o,
  output power_mode_pkg::core_power_s core_o,
  output power_mode_pkg::watchdog_power_s wdt_o,
  output logic periph_idle_o
);
  import power_mode_pkg::*;

  // ****************************************************************
  // pin inputs: stop recovery, both brown-out options and watchdog oscillator enable pass two flops
  // ****************************************************************
  logic [3:0] pins_sync;
  logic stop_recovery_s;
  logic bo_ao_s;
  logic bo_stop_s;
  logic wdt_osc_s;

  sync_two_ff #(.WIDTH(4)) pin_sync (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .clk_en_i(clk_en_i),
    .async_i({stop_recovery_i, brownout_always_on_option_i,
              brownout_stop_option_i, wdt_osc_enable_i}),
    .sync_o(pins_sync)
  );
  assign stop_recovery_s = pins_sync[3];
  assign bo_ao_s = pins_sync[2];
  assign bo_stop_s = pins_sync[1];
  assign wdt_osc_s = pins_sync[0];

  // ****************************************************************
  // register bus
  // ****************************************************************
  logic [7:0] periph_pwr_dis_q;
  power_mode_e mode_q;
  logic [7:0] mode_cmd_q;
  logic [31:0] rd_value;
  logic wr_stb;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;

  always_comb
  begin
    case (address_i)
      PERIPH_PWR_DIS_OFFSET: rd_value = {24'h000000, periph_pwr_dis_q}; // [R16]
      MODE_STATUS_OFFSET: rd_value = {30'h0, mode_q};
      MODE_CMD_OFFSET: rd_value = {24'h000000, mode_cmd_q};
      default: rd_value = UNMAPPED_READ;
    endcase
  end

  avalon_reg_slave bus (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .clk_en_i(clk_en_i),
    .address_i(address_i),
    .read_i(read_i),
    .write_i(write_i),
    .writedata_i(writedata_i),
    .byteenable_i(byteenable_i),
    .rd_value_i(rd_value),
    .waitrequest_o(waitrequest_o),
    .readdata_o(readdata_o),
    .wr_stb_o(wr_stb),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data)
  );

  // ****************************************************************
  // power control register
  // ****************************************************************
  // kept on the power-on reset alone so that system resets leave it intact
  always_ff @(posedge ref_clk_i or negedge por_n_i)
  begin
    if (!por_n_i)
      periph_pwr_dis_q <= PERIPH_PWR_DIS_RESET; // [R10] [R11]
    else if (clk_en_i && wr_stb && wr_addr == PERIPH_PWR_DIS_OFFSET)
      periph_pwr_dis_q <= wr_data; // [R16]
  end

  // software mode requests, for cores without dedicated instruction strobes
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      mode_cmd_q <= 8'h00;
    else if (clk_en_i)
    begin
      if (wr_stb && wr_addr == MODE_CMD_OFFSET)
        mode_cmd_q <= wr_data;
      else
        mode_cmd_q <= 8'h00;
    end
  end

  // ****************************************************************
  // mode state machine
  // ****************************************************************
  logic stop_req;
  logic halt_req;
  assign stop_req = stop_instr_i || mode_cmd_q[CMD_STOP_BIT];
  assign halt_req = halt_instr_i || mode_cmd_q[CMD_HALT_BIT];

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      mode_q <= MODE_ACTIVE;
    else if (clk_en_i)
    begin
      case (mode_q)
        MODE_ACTIVE:
        begin
          // stop wins when both requests arrive together
          if (stop_req)
            mode_q <= MODE_STOP; // [R1]
          else if (halt_req)
            mode_q <= MODE_HALT; // [R7]
        end
        MODE_HALT:
        begin
          if (stop_recovery_s || halt_wake_i)
            mode_q <= MODE_ACTIVE; // [R8]
        end
        MODE_STOP:
        begin
          if (stop_recovery_s)
            mode_q <= MODE_ACTIVE; // [R9]
        end
        default: mode_q <= MODE_ACTIVE;
      endcase
    end
  end

  // ****************************************************************
  // power outputs, registered
  // ****************************************************************
  logic in_stop;
  logic in_halt;
  assign in_stop = (mode_q == MODE_STOP);
  assign in_halt = (mode_q == MODE_HALT);

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      periph_en_o <= '0;
      periph_idle_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      periph_en_o.lpamp_en <= !periph_pwr_dis_q[LPAMP_DIS_BIT]; // [R6] [R11] [R15]
      periph_en_o.brownout_en <= !periph_pwr_dis_q[BROWNOUT_DIS_BIT] && bo_ao_s
        && (!in_stop || bo_stop_s); // [R5] [R12]
      periph_en_o.temp_en <= !periph_pwr_dis_q[TEMP_DIS_BIT] && !in_stop; // [R13] [R1]
      periph_en_o.adc_en <= !periph_pwr_dis_q[ADC_DIS_BIT] && !in_stop; // [R13] [R1]
      periph_en_o.comp_en <= !periph_pwr_dis_q[COMP_DIS_BIT] && !in_stop; // [R13] [R1]
      periph_idle_o <= in_stop; // [R1]
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      core_o <= '0;
      wdt_o <= '0;
      mode_o <= MODE_ACTIVE;
    end
    else if (clk_en_i)
    begin
      mode_o <= mode_q;
      core_o.sys_clk_en <= !in_stop; // [R3]
      core_o.cpu_run <= !in_stop && !in_halt; // [R3] [R7]
      core_o.pc_advance <= !in_stop && !in_halt; // [R3]
      core_o.main_osc_en <= !in_stop; // [R2]
      core_o.precision_osc_en <= !in_stop; // [R2]
      core_o.xtal_pins_en <= !in_stop; // [R2]
      core_o.port_a_gpio_restore <= in_stop; // [R2]
      wdt_o.wdt_osc_en <= wdt_osc_s; // [R4]
      wdt_o.wdt_logic_en <= wdt_enable_i && wdt_osc_s; // [R4]
    end
  end
endmodule

// File: low_power_mode_control_assertions.sv
`timescale 1ns/1ns
module low_power_mode_control_checker
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic waitrequest_o,
  input wire logic stop_instr_i,
  input wire logic stop_recovery_i,
  input wire logic wdt_osc_enable_i,
  input wire logic wdt_enable_i,
  input wire power_mode_pkg::power_mode_e mode_o,
  input wire power_mode_pkg::periph_enable_s periph_en_o,
  input wire power_mode_pkg::core_power_s core_o,
  input wire power_mode_pkg::watchdog_power_s wdt_o,
  input wire logic periph_idle_o
);
  import power_mode_pkg::*;
  // ****
  // settle guard
  // ****
  // outputs need a few edges after release before they reflect state
  logic [2:0] up_q;
  wire req = read_i | write_i;
  wire up = up_q[2];
  wire stop = up && mode_o == MODE_STOP;
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      up_q <= 3'h0;
    else if (!up_q[2])
      up_q <= up_q + 3'h1;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_req_new;
    $rose(req) && waitrequest_o;
  endsequence
  sequence s_one_wait;
    !waitrequest_o ##1 waitrequest_o;
  endsequence
  a_req_one_wait: assert property (s_req_new |=> s_one_wait)
    else $error("bus answer not after one wait cycle");
  a_stop_enter: assert property (up && stop_instr_i |-> ##[1:2] mode_o == MODE_STOP)
    else $error("stop not entered");
  a_stop_core_off: assert property (stop |-> core_o == 7'h01)
    else $error("core not halted in stop");
  a_stop_idle: assert property (stop |-> periph_idle_o && periph_en_o[2:0] == 3'h0)
    else $error("peripherals not idle in stop");
  a_halt_cpu_only: assert property (up && mode_o == MODE_HALT |->
    !core_o.cpu_run && core_o.sys_clk_en && core_o.main_osc_en)
    else $error("halt powers wrong blocks");
  a_active_running: assert property (up && mode_o == MODE_ACTIVE |->
    core_o.cpu_run && core_o.pc_advance)
    else $error("cpu not running in active");
  a_stop_holds: assert property (stop && !stop_recovery_i && !$past(stop_recovery_i) &&
    !$past(stop_recovery_i, 2) && !$past(stop_recovery_i, 3) |=> mode_o == MODE_STOP)
    else $error("stop left without recovery");
  a_stop_exit: assert property (stop && $rose(stop_recovery_i) |-> ##[2:6] mode_o == MODE_ACTIVE)
    else $error("recovery did not leave stop");
  a_wdt_in_stop: assert property (stop && wdt_enable_i && $past(wdt_enable_i) &&
    wdt_osc_enable_i && $past(wdt_osc_enable_i, 3) |-> wdt_o == 2'h3)
    else $error("watchdog stopped in stop");
endmodule
bind low_power_mode_control low_power_mode_control_checker chk (
  .ref_clk_i(ref_clk_i),
  .rstn_i(rstn_i),
  .read_i(read_i),
  .write_i(write_i),
  .waitrequest_o(waitrequest_o),
  .stop_instr_i(stop_instr_i),
  .stop_recovery_i(stop_recovery_i),
  .wdt_osc_enable_i(wdt_osc_enable_i),
  .wdt_enable_i(wdt_enable_i),
  .mode_o(mode_o),
  .periph_en_o(periph_en_o),
  .core_o(core_o),
  .wdt_o(wdt_o),
  .periph_idle_o(periph_idle_o)
);

// File: power_mode_pkg.sv
package power_mode_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] PERIPH_PWR_DIS_OFFSET = 12'hf80;
  localparam logic [ADDR_W-1:0] MODE_STATUS_OFFSET = 12'hf84;
  localparam logic [ADDR_W-1:0] MODE_CMD_OFFSET = 12'hf88;
  localparam logic [7:0] PERIPH_PWR_DIS_RESET = 8'h80;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ****************************************************************
  // field positions of peripheral_power_disable
  // ****************************************************************
  localparam int LPAMP_DIS_BIT = 7;
  localparam int BROWNOUT_DIS_BIT = 4;
  localparam int TEMP_DIS_BIT = 3;
  localparam int ADC_DIS_BIT = 2;
  localparam int COMP_DIS_BIT = 1;

  // mode command register bits
  localparam int CMD_STOP_BIT = 0;
  localparam int CMD_HALT_BIT = 1;

  // wait states the bus slave inserts before it accepts a request
  localparam logic [1:0] BUS_WAIT_CYCLES = 2'h1;

  typedef enum logic [1:0] {
    MODE_ACTIVE,
    MODE_HALT,
    MODE_STOP
  } power_mode_e;

  typedef struct packed {
    logic lpamp_en;
    logic brownout_en;
    logic temp_en;
    logic adc_en;
    logic comp_en;
  } periph_enable_s;

  typedef struct packed {
    logic sys_clk_en;
    logic cpu_run;
    logic pc_advance;
    logic main_osc_en;
    logic precision_osc_en;
    logic xtal_pins_en;
    logic port_a_gpio_restore;
  } core_power_s;

  typedef struct packed {
    logic wdt_osc_en;
    logic wdt_logic_en;
  } watchdog_power_s;

endpackage

// File: sync_two_ff.sv
`timescale 1ns/1ns
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds the second and nothing else
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else if (clk_en_i)
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// File: tb.sv
`timescale 1ns/1ns
module tb;
  import power_mode_pkg::*;
  logic ref_clk_i, rstn_i, clk_en_i, por_n_i, read_i, write_i, waitrequest_o, periph_idle_o;
  logic [ADDR_W-1:0] address_i;
  logic [31:0] writedata_i, readdata_o, q;
  logic [3:0] byteenable_i;
  logic stop_instr_i, halt_instr_i, halt_wake_i, stop_recovery_i, wdt_osc_enable_i, wdt_enable_i;
  logic brownout_always_on_option_i, brownout_stop_option_i;
  power_mode_e mode_o;
  periph_enable_s periph_en_o;
  core_power_s core_o;
  watchdog_power_s wdt_o;
  int n_errors, total_checks, cycles;
  int bitpos[5] = '{1, 2, 3, 4, 7};
  low_power_mode_control DUT (.*);
  cpu_core_model cpu (.ref_clk_i, .waitrequest_i(waitrequest_o), .readdata_i(readdata_o),
    .address_o(address_i), .read_o(read_i), .write_o(write_i), .writedata_o(writedata_i),
    .byteenable_o(byteenable_i), .stop_instr_o(stop_instr_i), .halt_instr_o(halt_instr_i));
  // ****
  // checks and report
  // ****
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic reg_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    cpu.access(a, 1'b0, 8'h00, q);
    chk("readdata", exp, q);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // tests need little more than a hundred cycles; the ceiling leaves wide margin
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      complete_run();
    end
  end
  initial
  begin
    rstn_i = 1'b0;
    por_n_i = 1'b0;
    clk_en_i = 1'b1;
    halt_wake_i = 1'b0;
    stop_recovery_i = 1'b0;
    brownout_always_on_option_i = 1'b1;
    brownout_stop_option_i = 1'b0;
    wdt_osc_enable_i = 1'b1;
    wdt_enable_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    por_n_i <= 1'b1;
    reg_chk(PERIPH_PWR_DIS_OFFSET, 32'h80);
    foreach (bitpos[i])
    begin
      cpu.access(PERIPH_PWR_DIS_OFFSET, 1'b1, 8'h01 << bitpos[i], q);
      reg_chk(PERIPH_PWR_DIS_OFFSET, 32'h1 << bitpos[i]);
      chk("periph_en", 5'h1f ^ (5'h01 << i), periph_en_o);
    end
    // brown-out bit left clear: only the missing option turns the detector off
    cpu.access(PERIPH_PWR_DIS_OFFSET, 1'b1, 8'h02, q);
    brownout_always_on_option_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    chk("periph_en", 5'h16, periph_en_o);
    brownout_always_on_option_i <= 1'b1;
    rstn_i <= 1'b0;
    @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    reg_chk(PERIPH_PWR_DIS_OFFSET, 32'h02);
    reg_chk(12'hf90, UNMAPPED_READ);
    reg_chk(MODE_STATUS_OFFSET, MODE_ACTIVE);
    cpu.instr(1'b0);
    repeat (2) @(posedge ref_clk_i);
    chk("cpu_run", 1'b0, core_o.cpu_run);
    chk("sys_clk", 1'b1, core_o.sys_clk_en);
    reg_chk(MODE_STATUS_OFFSET, MODE_HALT);
    halt_wake_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk("mode", MODE_ACTIVE, mode_o);
    halt_wake_i <= 1'b0;
    cpu.access(MODE_CMD_OFFSET, 1'b1, 8'h02, q);
    repeat (3) @(posedge ref_clk_i);
    chk("mode", MODE_HALT, mode_o);
    reg_chk(MODE_CMD_OFFSET, 32'h0);
    halt_wake_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk("mode", MODE_ACTIVE, mode_o);
    cpu.access(PERIPH_PWR_DIS_OFFSET, 1'b1, 8'h00, q);
    cpu.instr(1'b1);
    repeat (2) @(posedge ref_clk_i);
    chk("mode", MODE_STOP, mode_o);
    chk("core", 7'h01, core_o);
    chk("periph_en", 5'h10, periph_en_o);
    chk("wdt", 2'h3, wdt_o);
    chk("idle", 1'b1, periph_idle_o);
    repeat (6) @(posedge ref_clk_i);
    chk("mode", MODE_STOP, mode_o);
    stop_recovery_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    chk("mode", MODE_ACTIVE, mode_o);
    stop_recovery_i <= 1'b0;
    halt_wake_i <= 1'b0;
    brownout_stop_option_i <= 1'b1;
    wdt_enable_i <= 1'b0;
    cpu.access(PERIPH_PWR_DIS_OFFSET, 1'b1, 8'h80, q);
    cpu.instr(1'b1);
    repeat (2) @(posedge ref_clk_i);
    chk("periph_en", 5'h08, periph_en_o);
    chk("wdt", 2'h2, wdt_o);
    rstn_i <= 1'b0;
    por_n_i <= 1'b0;
    @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    por_n_i <= 1'b1;
    reg_chk(PERIPH_PWR_DIS_OFFSET, PERIPH_PWR_DIS_RESET);
    complete_run();
  end
endmodule
